// *** src/pst_pkg.sv ***
/*
  Shared constants and types for the printer status output block.
  Assumes a 100 MHz core clock and active-low reset released by the top module.
*/
package pst_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Stock level width, ribbon compare
  localparam int STOCK_W = 16;

  // Ribbon warning release delay after roll change
  localparam int RIBBON_CLR_TIME_MS = 100;
  localparam int RIBBON_CLR_CYCLES  = RIBBON_CLR_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RIBBON_CNT_W       = 24;

  // End-of-print pulse length
  localparam int PE_PULSE_TIME_US = 10;
  localparam int PE_PULSE_CYCLES  = PE_PULSE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PE_CNT_W         = 10;

  // Output reset levels (all lines inactive)
  localparam logic WARN_RST      = 1'b0;
  localparam logic ERR_N_RST     = 1'b1;
  localparam logic PEND_N_RST    = 1'b1;
  localparam logic EMPTY_N_RST   = 1'b1;
  localparam logic MSTAT_N_RST   = 1'b1;

  // Interface profile
  typedef enum logic [1:0] {
    PROF_STANDARD = 2'h1,
    PROF_BAD_TAG  = 2'h2
  } pst_profile_e;

  // End-of-print switching mode
  typedef enum logic [1:0] {
    PE_MODE_LEVEL = 2'h1,
    PE_MODE_PULSE = 2'h2
  } pst_pe_mode_e;

  // End-of-print pulse state
  typedef enum logic [1:0] {
    PE_IDLE  = 2'h1,
    PE_PULSE = 2'h2
  } pst_pe_state_e;

endpackage

// *** src/pst_status_out.sv ***
/*
  Status output lines of the label printer discrete interface: warning,
  error, end-of-print / home position, stock empty and machine status.
  Assumes controller inputs are on clk; light barrier and applicator
  home sensor are pin levels and are synchronised here.
*/
`timescale 1ns/100ps
// Function
// - Ribbon low and enabled raises warning
// - Material low and enabled raises warning
// - Warning low only when both supplies sufficient
// - Ribbon warning clears after delay on change
// - Warning never stalls printing
// - Bad-tag profile and tag fault raise warning
// - Error low when offline or error
// - Error high when online without error or material end
// - Error high during initialization
// - End-print mode selects output behaviour
// - End-print output active while feeding
// - No end-print behaviour in batch mode
// - Applicator fitted: line shows home position
// - Home output low at upper limit
// - Material end: empty, error, status low
// - Machine status low on print interruption
// - Machine status high for offline/pause only
module pst_status_out
  import pst_pkg::*;
#(
  parameter int RIBBON_CLR_CYC = RIBBON_CLR_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  // Configuration
  input  wire logic               ribbon_sig_en,
  input  wire logic               material_sig_en,
  input  wire pst_profile_e       interface_profile_select,
  input  wire pst_pe_mode_e       print_end_mode,
  input  wire logic               batch_mode,
  input  wire logic               applicator_fitted,
  input  wire logic [STOCK_W-1:0] ribbon_warn_thresh,
  // Printer state
  input  wire logic [STOCK_W-1:0] ribbon_stock,
  input  wire logic               ribbon_replaced,
  input  wire logic               tag_fault,
  input  wire logic               tag_fault_clr,
  input  wire logic               initializing,
  input  wire logic               online,
  input  wire logic               error_present,
  input  wire logic               print_interrupted,
  input  wire logic               material_end,
  input  wire logic               printing,
  input  wire logic               label_done,
  input  wire logic               feeding,
  // Sensor pins
  input  wire logic               material_low_pin,
  input  wire logic               applicator_home_pin,
  // Status lines
  output logic                    warning,
  output logic                    error_n,
  output logic                    print_end_n,
  output logic                    label_stock_empty_n,
  output logic                    machine_status_n,
  output logic                    print_inhibit
);

  logic [1:0] rst_sync_q;
  logic       rst_n_q;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'h0;
    else if (clk_en)
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_q = rst_sync_q[1];

  logic material_low;
  logic app_home;

  pst_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk    (clk),
    .rst_n  (rst_n_q),
    .clk_en (clk_en),
    .d      ({material_low_pin, applicator_home_pin}),
    .q      ({material_low, app_home})
  );

  // Ribbon and tag warning state
  logic [RIBBON_CNT_W-1:0] rib_cnt_q, rib_cnt_d;
  logic                    rib_warn_q, rib_warn_d;
  logic                    tag_flag_q, tag_flag_d;
  logic                    ribbon_low;

  always_comb
  begin
    ribbon_low = ribbon_sig_en && (ribbon_stock < ribbon_warn_thresh);
    rib_cnt_d  = rib_cnt_q;
    rib_warn_d = rib_warn_q;
    if (ribbon_replaced)
      rib_cnt_d = RIBBON_CNT_W'(RIBBON_CLR_CYC);
    else if (rib_cnt_q != '0)
      rib_cnt_d = rib_cnt_q - 1'b1;
    // Old state held while the new roll settles
    if (!ribbon_replaced && rib_cnt_q == '0)
      rib_warn_d = ribbon_low;
    // Set wins over clear
    tag_flag_d = (tag_flag_q && !tag_fault_clr) || tag_fault;
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rib_cnt_q  <= '0;
      rib_warn_q <= WARN_RST;
      tag_flag_q <= 1'b0;
    end
    else if (clk_en)
    begin
      rib_cnt_q  <= rib_cnt_d;
      rib_warn_q <= rib_warn_d;
      tag_flag_q <= tag_flag_d;
    end
  end

  // End-of-print pulse
  pst_pe_state_e         pe_state_q, pe_state_d;
  logic [PE_CNT_W-1:0]   pe_cnt_q, pe_cnt_d;

  always_comb
  begin
    pe_state_d = pe_state_q;
    pe_cnt_d   = pe_cnt_q;
    case (pe_state_q)
      PE_IDLE:
      begin
        if (label_done && !batch_mode)
        begin
          pe_state_d = PE_PULSE;
          pe_cnt_d   = PE_CNT_W'(PE_PULSE_CYCLES - 1);
        end
      end
      PE_PULSE:
      begin
        if (pe_cnt_q == '0)
          pe_state_d = PE_IDLE;
        else
          pe_cnt_d = pe_cnt_q - 1'b1;
      end
      default:
      begin
        pe_state_d = PE_IDLE;
        pe_cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pe_state_q <= PE_IDLE;
      pe_cnt_q   <= '0;
    end
    else if (clk_en)
    begin
      pe_state_q <= pe_state_d;
      pe_cnt_q   <= pe_cnt_d;
    end
  end

  // Output lines
  logic warn_d, err_n_d, pend_n_d, empty_n_d, mstat_n_d, inhibit_d;
  logic pe_active;

  always_comb
  begin
    warn_d = rib_warn_q
          || (material_sig_en && material_low)
          || (interface_profile_select == PROF_BAD_TAG && tag_flag_q);
    if (initializing)
      err_n_d = 1'b1;
    else
      err_n_d = online && !error_present && !material_end;
    case (print_end_mode)
      PE_MODE_LEVEL: pe_active = printing;
      PE_MODE_PULSE: pe_active = (pe_state_q == PE_PULSE);
      default:       pe_active = 1'b0;
    endcase
    pe_active = !batch_mode && (pe_active || feeding);
    if (applicator_fitted)
      pend_n_d = !app_home;
    else
      pend_n_d = !pe_active;
    empty_n_d = !material_end;
    // Offline or pause alone leaves this line high
    mstat_n_d = !(print_interrupted || error_present || material_end);
    // Warnings are advisory and never inhibit printing
    inhibit_d = !mstat_n_d;
  end

  // Registered so no line glitches as inputs change
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      warning             <= WARN_RST;
      error_n             <= ERR_N_RST;
      print_end_n         <= PEND_N_RST;
      label_stock_empty_n <= EMPTY_N_RST;
      machine_status_n    <= MSTAT_N_RST;
      print_inhibit       <= 1'b0;
    end
    else if (clk_en)
    begin
      warning             <= warn_d;
      error_n             <= err_n_d;
      print_end_n         <= pend_n_d;
      label_stock_empty_n <= empty_n_d;
      machine_status_n    <= mstat_n_d;
      print_inhibit       <= inhibit_d;
    end
  end

  // Checks wait one enabled edge after release; the output flops
  // are still held at the release edge itself
  logic chk_live_q;

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      chk_live_q <= 1'b0;
    else if (clk_en)
      chk_live_q <= 1'b1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!chk_live_q);

  ribbon_warn_set_a: assert property (
    clk_en && ribbon_sig_en && ribbon_stock < ribbon_warn_thresh && rib_cnt_q == '0 && !ribbon_replaced
    ##1 clk_en |=> warning)
    else $error("ribbon low did not raise warning");

  material_warn_a: assert property (
    clk_en && material_sig_en && material_low |=> warning)
    else $error("material low did not raise warning");

  warn_low_only_a: assert property (
    clk_en && !warning && $past(clk_en) |-> !$past(rib_warn_q) && !($past(material_sig_en) && $past(material_low)))
    else $error("warning low while a supply is short");

  ribbon_hold_a: assert property (
    clk_en && ribbon_replaced |=> (rib_cnt_q == RIBBON_CNT_W'(RIBBON_CLR_CYC)) && $stable(rib_warn_q))
    else $error("ribbon change did not start release delay");

  warn_no_stall_a: assert property (
    clk_en && warn_d && mstat_n_d |=> !print_inhibit)
    else $error("warning inhibited printing");

  bad_tag_a: assert property (
    clk_en && interface_profile_select == PROF_BAD_TAG && tag_fault
    ##1 clk_en && !tag_fault_clr && interface_profile_select == PROF_BAD_TAG |=> warning)
    else $error("tag fault did not raise warning");

  err_offline_a: assert property (
    clk_en && !initializing && (!online || error_present) |=> !error_n)
    else $error("error line high while offline or faulted");

  err_online_a: assert property (
    clk_en && !initializing && online && !error_present && !material_end |=> error_n)
    else $error("error line low while online and clean");

  err_init_a: assert property (
    clk_en && initializing |=> error_n)
    else $error("error line low during initialization");

  pe_pulse_len_a: assert property (
    clk_en && pe_state_q == PE_IDLE && label_done && !batch_mode ##1 clk_en [*3] |-> pe_state_q == PE_PULSE)
    else $error("end-print pulse ended early");

  pe_feed_a: assert property (
    clk_en && feeding && !batch_mode && !applicator_fitted |=> !print_end_n)
    else $error("end-print line inactive while feeding");

  pe_batch_a: assert property (
    clk_en && batch_mode && !applicator_fitted |=> print_end_n)
    else $error("end-print line active in batch mode");

  home_pos_a: assert property (
    clk_en && applicator_fitted |=> print_end_n == !$past(app_home))
    else $error("home line does not follow applicator");

  media_end_a: assert property (
    clk_en && material_end && !initializing |=> !label_stock_empty_n && !error_n && !machine_status_n)
    else $error("material end not signalled on all lines");

  mstat_int_a: assert property (
    clk_en && print_interrupted |=> !machine_status_n)
    else $error("status line high on interruption");

  mstat_off_a: assert property (
    clk_en && !online && !print_interrupted && !error_present && !material_end |=> machine_status_n)
    else $error("status line low for offline only");

  out_frozen_a: assert property (
    !clk_en |=> $stable(error_n) && $stable(warning) && $stable(machine_status_n))
    else $error("outputs moved with clock enable low");

  cov_ribbon_c:  cover property (clk_en && ribbon_replaced ##1 rib_cnt_q != '0);
  cov_pulse_c:   cover property (pe_state_q == PE_PULSE ##1 pe_state_q == PE_IDLE);
  cov_media_c:   cover property (!label_stock_empty_n && !error_n);
  cov_home_c:    cover property (applicator_fitted && !print_end_n);

endmodule // pst_status_out

// *** src/pst_sync.sv ***
/*
  Two-flop synchroniser for pin-level inputs, WIDTH bits wide.
  Assumes inputs are slow levels; no bus coherency between bits.
*/
`timescale 1ns/100ps
module pst_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else if (clk_en)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // pst_sync

// *** testbench/pst_plc_model.sv ***
/*
  Host controller model: watches the end-print line and times end-print pulses.
  Assumes the lines are registered on clk and sampled at its rising edge.
*/
`timescale 1ns/100ps
module pst_plc_model (
  // Clock
  input  wire logic        clk,
  // Status lines
  input  wire logic        print_end_n,
  // Pulse timing
  output logic      [15:0] low_len,
  output logic      [7:0]  pulses
);
  logic [15:0] cnt;
  initial
  begin
    cnt     = 16'h0000;
    low_len = 16'h0000;
    pulses  = 8'h00;
  end
  // Length in sampled edges, as a host polling each cycle would see it
  always @(posedge clk)
  begin
    if (print_end_n === 1'b0)
      cnt <= cnt + 16'h0001;
    else if (cnt != 16'h0000)
    begin
      low_len <= cnt;
      pulses  <= pulses + 8'h01;
      cnt     <= 16'h0000;
    end
  end
endmodule // pst_plc_model

// *** testbench/test_pst_status_out.sv ***
/*
  Self-checking bench for the status output block, table rows then edge cases.
  Assumes the design and package under src/ are compiled first.
*/
`timescale 1ns/100ps
module test_pst_status_out
  import pst_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0;
  logic cen = 1'b1, ren = 1'b0, men = 1'b0, batch = 1'b0, appl = 1'b0, rrep = 1'b0, tf = 1'b0, tfc = 1'b0;
  logic init = 1'b0, on = 1'b0, err = 1'b0, intr = 1'b0, mend = 1'b0, prt = 1'b0, done = 1'b0;
  logic feed = 1'b0, mlow = 1'b0, home = 1'b0;
  pst_profile_e prof = PROF_STANDARD;
  pst_pe_mode_e mode = PE_MODE_LEVEL;
  logic [STOCK_W-1:0] stock = 16'h0200;
  logic warn, err_n, pe_n, emp_n, ms_n, inh;
  logic [15:0] low_len;
  logic [7:0] pulses;
  logic [7:0] base_pulses;
  int fails = 0, checks = 0;
  logic [12:0] rows [12] = '{13'h1007, 13'h1406, 13'h0003, 13'h1802, 13'h1200, 13'h0802, 13'h0906,
                             13'h10CF, 13'h1087, 13'h103F, 13'h1027, 13'h10FF};
  always #5 clk = ~clk;

  pst_status_out #(.RIBBON_CLR_CYC(20)) i_dut (
    .clk(clk), .rst_b(rst_b), .clk_en(cen), .ribbon_sig_en(ren), .material_sig_en(men),
    .interface_profile_select(prof), .print_end_mode(mode), .batch_mode(batch),
    .applicator_fitted(appl), .ribbon_warn_thresh(16'h0100), .ribbon_stock(stock),
    .ribbon_replaced(rrep), .tag_fault(tf), .tag_fault_clr(tfc), .initializing(init), .online(on),
    .error_present(err), .print_interrupted(intr), .material_end(mend), .printing(prt),
    .label_done(done), .feeding(feed), .material_low_pin(mlow), .applicator_home_pin(home),
    .warning(warn), .error_n(err_n), .print_end_n(pe_n), .label_stock_empty_n(emp_n),
    .machine_status_n(ms_n), .print_inhibit(inh));

  pst_plc_model i_plc (.clk(clk), .print_end_n(pe_n), .low_len(low_len), .pulses(pulses));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One-cycle strobe driven between falling edges
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  initial
  begin
    cyc(20);
    check(16'({warn, err_n, pe_n, emp_n, ms_n, inh}), 16'h001E);
    rst_b = 1'b1;
    cyc(5);
    foreach (rows[i])
    begin
      {on, err, intr, mend, init} = rows[i][12:8];
      stock = rows[i][7] ? 16'h00FF : 16'h0100;
      {ren, mlow, men} = rows[i][6:4];
      cyc(4);
      check(16'({warn, err_n, emp_n, ms_n}), 16'(rows[i][3:0]));
      check(16'(inh), 16'(!rows[i][0]));
    end
    // Roll change: warning holds through the release delay, then drops
    {mlow, men, ren} = 3'h1;
    stock = 16'h00FF;
    cyc(4);
    stock = 16'h0100;
    pulse(rrep);
    cyc(5);
    check(16'(warn), 16'h0001);
    cyc(30);
    check(16'(warn), 16'h0000);
    // Tag fault only counts under the bad-tag profile
    pulse(tf);
    cyc(3);
    check(16'(warn), 16'h0000);
    pulse(tfc);
    prof = PROF_BAD_TAG;
    pulse(tf);
    cyc(3);
    check(16'(warn), 16'h0001);
    pulse(tfc);
    cyc(3);
    check(16'(warn), 16'h0000);
    // Fault and clear in one cycle: the fault wins
    {tf, tfc} = 2'h3;
    cyc(1);
    {tf, tfc} = 2'h0;
    cyc(2);
    check(16'(warn), 16'h0001);
    pulse(tfc);
    cyc(3);
    check(16'(warn), 16'h0000);
    // Level mode follows printing and feeding, batch masks feeding
    prt = 1'b1;
    cyc(2);
    check(16'(pe_n), 16'h0000);
    prt = 1'b0;
    feed = 1'b1;
    cyc(2);
    check(16'(pe_n), 16'h0000);
    batch = 1'b1;
    cyc(2);
    check(16'(pe_n), 16'h0001);
    // Undefined mode code leaves the line idle while printing
    {batch, feed, prt} = 3'h1;
    mode = pst_pe_mode_e'(2'h3);
    cyc(2);
    check(16'(pe_n), 16'h0001);
    // Model has already counted the level phase as one low period
    base_pulses = pulses;
    {batch, prt} = 2'h2;
    mode = PE_MODE_PULSE;
    pulse(done);
    cyc(20);
    check(16'(pulses), 16'(base_pulses));
    batch = 1'b0;
    pulse(done);
    for (int i = 0; i < 1200 && pulses == base_pulses; i++)
      cyc(1);
    if (pulses == base_pulses)
      fails++;
    else
      check(low_len, 16'(PE_PULSE_CYCLES));
    // Applicator fitted: line tracks the home sensor pin
    appl = 1'b1;
    home = 1'b1;
    cyc(4);
    check(16'(pe_n), 16'h0000);
    home = 1'b0;
    cyc(4);
    check(16'(pe_n), 16'h0001);
    // Clock enable low freezes the error output
    cen = 1'b0;
    on = 1'b0;
    cyc(3);
    check(16'(err_n), 16'h0001);
    cen = 1'b1;
    cyc(2);
    check(16'(err_n), 16'h0000);
    give_verdict();
  end
endmodule // test_pst_status_out
